// *** hw/digipot_control.sv ***
// Purpose: control pins and command execution of a nonvolatile digital potentiometer
// Assumes: all pins except SYS_CLK and SYS_RST are asynchronous to SYS_CLK and pass two flip-flops first
// Notes: the analog wiper is represented only by its setting register
// ============================================================================
// What this block does
// - write-protect low blocks serial writes to store and wiper; reload commands and preset still set the wiper
// - preset copies the nonvolatile store into wiper
// - preset fires on the rising edge only
// - store holds midscale until the user saves
// - commands execute when chip select returns high
// - ready is active low and open drain
// - ready marks completion of commands 2,3,8,9,10
// - output two follows D1 at location one
// - output one follows D0 at location one
// - one serial bit taken per clock rise
module digipot_control #(
  parameter int WIPER_BITS = 10,
  parameter int NV_PROG_TIME_US = 25000
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic SPI_CLK,
  input wire logic SERIAL_IN,
  input wire logic CS_N,
  input wire logic WRITE_PROTECT_N,
  input wire logic HW_PRESET_RELOAD,
  output logic SERIAL_OUT_O,
  output logic SERIAL_OUT_OE_N,
  output logic READY_O,
  output logic READY_OE_N,
  output logic NV_OUTPUT_ONE,
  output logic NV_OUTPUT_TWO,
  output logic [WIPER_BITS-1:0] WIPER_SETTING
);

  // ==========================================================================
  // constants
  // ==========================================================================
  localparam int PROG_CYCLES = NV_PROG_TIME_US * digipot_pkg::SYS_CLK_MHZ;
  localparam int TIMER_BITS = $clog2(PROG_CYCLES + 1);
  localparam int DW = digipot_pkg::DATA_BITS;
  localparam logic [WIPER_BITS-1:0] MIDSCALE = {1'b1, {(WIPER_BITS-1){1'b0}}};

  typedef enum logic [1:0] {IDLE, BUSY} exec_e;

  function automatic logic [DW-1:0] widen(input logic [WIPER_BITS-1:0] w);
    widen = {{(DW-WIPER_BITS){1'b0}}, w};
  endfunction

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic frame_valid, serial_bit;
  digipot_pkg::frame_s frame;
  logic [DW-1:0] store_mem [digipot_pkg::STORE_WORDS];
  logic [WIPER_BITS-1:0] wiper_r;
  logic [1:0] wp_sync_r;
  logic [2:0] preset_sync_r;
  logic preset_rise, protect, take, writes_setting, starts_busy;
  logic load_valid_r;
  logic [DW-1:0] load_word_r;
  exec_e state_r;
  logic [TIMER_BITS-1:0] timer_r;

  // ==========================================================================
  // serial port
  // ==========================================================================
  serial_frame_shifter #(
    .FRAME_BITS(digipot_pkg::FRAME_BITS)
  ) u_shifter (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .spi_clk_pin(SPI_CLK),
    .serial_in_pin(SERIAL_IN),
    .cs_n_pin(CS_N),
    .load_valid(load_valid_r),
    .load_word(load_word_r),
    .frame_valid(frame_valid),
    .frame(frame),
    .serial_bit(serial_bit)
  );

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      wp_sync_r <= 2'h3;
      preset_sync_r <= 3'h0;
    end else begin
      wp_sync_r <= {wp_sync_r[0], WRITE_PROTECT_N};
      preset_sync_r <= {preset_sync_r[1:0], HW_PRESET_RELOAD};
    end
  end

  assign protect = ~wp_sync_r[1];
  assign preset_rise = preset_sync_r[1] & ~preset_sync_r[2];

  // frames arriving while a command is still busy are dropped
  assign take = frame_valid && state_r == IDLE;
  assign writes_setting = frame.cmd == digipot_pkg::CMD_SAVE_WIPER
    || frame.cmd == digipot_pkg::CMD_WRITE_STORE
    || frame.cmd == digipot_pkg::CMD_WRITE_WIPER;
  // only commands that report completion pull ready low; others leave it released
  assign starts_busy = take && (frame.cmd inside {digipot_pkg::CMD_RESET,
    digipot_pkg::CMD_READ_STORE, digipot_pkg::CMD_READ_WIPER}
    || (!protect && (frame.cmd == digipot_pkg::CMD_SAVE_WIPER
    || frame.cmd == digipot_pkg::CMD_WRITE_STORE)));

  // ==========================================================================
  // nonvolatile store
  // ==========================================================================
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < digipot_pkg::STORE_WORDS; i++) begin
        store_mem[i] <= digipot_pkg::STORE_RESET;
      end
      store_mem[digipot_pkg::ADDR_WIPER_STORE] <= widen(MIDSCALE);
    end else if (take && !protect && writes_setting) begin
      if (frame.cmd == digipot_pkg::CMD_SAVE_WIPER) begin
        store_mem[digipot_pkg::ADDR_WIPER_STORE] <= widen(wiper_r);
      end else if (frame.cmd == digipot_pkg::CMD_WRITE_STORE) begin
        store_mem[frame.addr] <= frame.data;
      end
    end
  end

  // ==========================================================================
  // wiper setting register
  // ==========================================================================
  // a preset edge outranks a same-cycle serial write: the pin is the override
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      wiper_r <= MIDSCALE;
    end else if (preset_rise) begin
      wiper_r <= store_mem[digipot_pkg::ADDR_WIPER_STORE][WIPER_BITS-1:0];
    end else if (take) begin
      if (frame.cmd == digipot_pkg::CMD_RELOAD_WIPER || frame.cmd == digipot_pkg::CMD_RESET) begin
        wiper_r <= store_mem[digipot_pkg::ADDR_WIPER_STORE][WIPER_BITS-1:0];
      end else if (frame.cmd == digipot_pkg::CMD_WRITE_WIPER && !protect) begin
        wiper_r <= frame.data[WIPER_BITS-1:0];
      end
    end
  end

  // ==========================================================================
  // readback load into the shifter
  // ==========================================================================
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      load_valid_r <= 1'b0;
      load_word_r <= '0;
    end else begin
      load_valid_r <= take && (frame.cmd == digipot_pkg::CMD_READ_STORE
        || frame.cmd == digipot_pkg::CMD_READ_WIPER);
      load_word_r <= frame.cmd == digipot_pkg::CMD_READ_STORE ? store_mem[frame.addr]
        : widen(wiper_r);
    end
  end

  // ==========================================================================
  // completion tracking for ready
  // ==========================================================================
  // slow store writes hold ready low for the programming time; refused writes don't
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_r <= IDLE;
      timer_r <= '0;
    end else begin
      unique case (state_r)
        IDLE: begin
          if (take) begin
            unique case (frame.cmd)
              digipot_pkg::CMD_SAVE_WIPER, digipot_pkg::CMD_WRITE_STORE: begin
                if (!protect) begin
                  state_r <= BUSY;
                  timer_r <= TIMER_BITS'(PROG_CYCLES - 1);
                end
              end
              digipot_pkg::CMD_RESET, digipot_pkg::CMD_READ_STORE,
              digipot_pkg::CMD_READ_WIPER: begin
                state_r <= BUSY;
                timer_r <= TIMER_BITS'(digipot_pkg::SHORT_CMD_CYCLES - 1);
              end
              default: begin
                state_r <= IDLE;
              end
            endcase
          end
        end
        BUSY: begin
          if (timer_r == '0) begin
            state_r <= IDLE;
          end else begin
            timer_r <= timer_r - 1'b1;
          end
        end
        default: begin
          state_r <= IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // output flops
  // ==========================================================================
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      READY_O <= 1'b0;
      READY_OE_N <= 1'b1;
      SERIAL_OUT_O <= 1'b0;
      SERIAL_OUT_OE_N <= 1'b1;
    end else begin
      READY_O <= 1'b0;
      READY_OE_N <= ~(state_r == BUSY || starts_busy);
      SERIAL_OUT_O <= 1'b0;
      SERIAL_OUT_OE_N <= serial_bit;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      NV_OUTPUT_ONE <= 1'b0;
      NV_OUTPUT_TWO <= 1'b0;
      WIPER_SETTING <= MIDSCALE;
    end else begin
      NV_OUTPUT_ONE <= store_mem[digipot_pkg::ADDR_NV_OUTPUTS][digipot_pkg::NV_OUT_ONE_BIT];
      NV_OUTPUT_TWO <= store_mem[digipot_pkg::ADDR_NV_OUTPUTS][digipot_pkg::NV_OUT_TWO_BIT];
      WIPER_SETTING <= wiper_r;
    end
  end

endmodule

// *** hw/digipot_pkg.sv ***
// Purpose: shared constants and types for the digital potentiometer control port
// Assumes: one 20 MHz system clock; serial pins arrive asynchronously
// Notes: command codes and frame layout are fixed here and used by both design files
package digipot_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int SYS_CLK_MHZ = 20;
  localparam int SHORT_CMD_CYCLES = 2;

  // ==========================================================================
  // serial frame layout
  // ==========================================================================
  localparam int FRAME_BITS = 24;
  localparam int CMD_BITS = 4;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam int STORE_WORDS = 16;

  typedef struct packed {
    logic [CMD_BITS-1:0] cmd;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;
  } frame_s;

  // ==========================================================================
  // command codes
  // ==========================================================================
  localparam logic [CMD_BITS-1:0] CMD_NOP = 4'h0;
  localparam logic [CMD_BITS-1:0] CMD_RELOAD_WIPER = 4'h1;
  localparam logic [CMD_BITS-1:0] CMD_SAVE_WIPER = 4'h2;
  localparam logic [CMD_BITS-1:0] CMD_WRITE_STORE = 4'h3;
  localparam logic [CMD_BITS-1:0] CMD_RESET = 4'h8;
  localparam logic [CMD_BITS-1:0] CMD_READ_STORE = 4'h9;
  localparam logic [CMD_BITS-1:0] CMD_READ_WIPER = 4'hA;
  localparam logic [CMD_BITS-1:0] CMD_WRITE_WIPER = 4'hB;

  // ==========================================================================
  // nonvolatile store map
  // ==========================================================================
  localparam logic [ADDR_BITS-1:0] ADDR_WIPER_STORE = 4'h0;
  localparam logic [ADDR_BITS-1:0] ADDR_NV_OUTPUTS = 4'h1;
  localparam int NV_OUT_ONE_BIT = 0;
  localparam int NV_OUT_TWO_BIT = 1;
  localparam logic [DATA_BITS-1:0] STORE_RESET = 16'h0000;

endpackage

// *** hw/serial_frame_shifter.sv ***
// Purpose: synchronise the serial pins, shift frames in and readback bits out
// Assumes: serial clock well below half the system clock rate
// Notes: a frame counts only if exactly FRAME_BITS edges came while selected
module serial_frame_shifter #(
  parameter int FRAME_BITS = digipot_pkg::FRAME_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_clk_pin,
  input wire logic serial_in_pin,
  input wire logic cs_n_pin,
  input wire logic load_valid,
  input wire logic [digipot_pkg::DATA_BITS-1:0] load_word,
  output logic frame_valid,
  output digipot_pkg::frame_s frame,
  output logic serial_bit
);

  // ==========================================================================
  // two-flop synchronisers, then a third stage for edges
  // ==========================================================================
  logic [2:0] sclk_r, cs_r;
  logic [1:0] din_r;
  logic [FRAME_BITS-1:0] shift_r;
  logic [digipot_pkg::CNT_BITS-1:0] cnt_r;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, selected;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_r <= 3'h0;
      cs_r <= 3'h7;
      din_r <= 2'h0;
    end else begin
      sclk_r <= {sclk_r[1:0], spi_clk_pin};
      cs_r <= {cs_r[1:0], cs_n_pin};
      din_r <= {din_r[0], serial_in_pin};
    end
  end

  assign sclk_rise = sclk_r[1] & ~sclk_r[2];
  assign sclk_fall = ~sclk_r[1] & sclk_r[2];
  assign cs_fall = ~cs_r[1] & cs_r[2];
  assign cs_rise = cs_r[1] & ~cs_r[2];
  assign selected = ~cs_r[1];

  // ==========================================================================
  // shift register and bit counter
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r <= '0;
    end else if (load_valid) begin
      shift_r <= {load_word, {(FRAME_BITS-digipot_pkg::DATA_BITS){1'b0}}};
    end else if (selected && sclk_rise) begin
      shift_r <= {shift_r[FRAME_BITS-2:0], din_r[1]};
    end
  end

  // counter saturates so an over-long frame can never wrap back to a valid count
  always_ff @(posedge clk) begin
    if (rst || cs_fall) begin
      cnt_r <= '0;
    end else if (selected && sclk_rise && cnt_r != '1) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // frame out on deselect, serial bit out on falling edges
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_valid <= 1'b0;
      frame <= '0;
    end else begin
      frame_valid <= cs_rise && cnt_r == digipot_pkg::CNT_BITS'(FRAME_BITS);
      frame <= shift_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      serial_bit <= 1'b1;
    end else if (!selected) begin
      serial_bit <= 1'b1;
    end else if (cs_fall || sclk_fall) begin
      serial_bit <= shift_r[FRAME_BITS-1];
    end
  end

endmodule

// *** tb/digipot_control_sva.sv ***
// Purpose: port checks of the potentiometer control block
// Assumes: program time shortened to 20 cycles
// Notes: watches top ports only, attached by bind
module digipot_control_sva #(
  parameter int WIPER_BITS = 10
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic CS_N,
  input wire logic WRITE_PROTECT_N,
  input wire logic HW_PRESET_RELOAD,
  input wire logic SERIAL_OUT_O,
  input wire logic SERIAL_OUT_OE_N,
  input wire logic READY_O,
  input wire logic READY_OE_N,
  input wire logic NV_OUTPUT_ONE,
  input wire logic NV_OUTPUT_TWO,
  input wire logic [WIPER_BITS-1:0] WIPER_SETTING
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [WIPER_BITS-1:0] mid_val = {1'b1, {(WIPER_BITS-1){1'b0}}};
  logic [3:0] quiet_r;
  logic [3:0] wp_r;
  logic cs_q_r;
  logic preset_q_r;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  // ====================
  // helper counters
  // ====================
  // more than 9 quiet cycles cover pin sync plus execute latency
  always_ff @(posedge SYS_CLK) begin
    cs_q_r <= CS_N;
    preset_q_r <= HW_PRESET_RELOAD;
    if (SYS_RST || CS_N != cs_q_r || HW_PRESET_RELOAD != preset_q_r) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || WRITE_PROTECT_N) begin
      wp_r <= 4'h0;
    end else if (wp_r != 4'hF) begin
      wp_r <= wp_r + 4'h1;
    end
  end
  // ====================
  // properties
  // ====================
  property p_ready_od;
    !READY_O;
  endproperty
  a_ready_od: assert property (p_ready_od) else $error("ready driven high");
  property p_dout_od;
    !SERIAL_OUT_O;
  endproperty
  a_dout_od: assert property (p_dout_od) else $error("data out driven high");
  property p_reset_vals;
    $fell(SYS_RST) |-> READY_OE_N && SERIAL_OUT_OE_N && WIPER_SETTING == mid_val
      && !NV_OUTPUT_ONE && !NV_OUTPUT_TWO;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
  property p_ready_min;
    $fell(READY_OE_N) |-> !READY_OE_N [*3];
  endproperty
  a_ready_min: assert property (p_ready_min) else $error("busy too short");
  property p_ready_max;
    $fell(READY_OE_N) |-> ##[1:21] READY_OE_N;
  endproperty
  a_ready_max: assert property (p_ready_max) else $error("busy too long");
  property p_ready_cause;
    $fell(READY_OE_N) |-> CS_N && !$past(CS_N, 8);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("busy without frame");
  property p_quiet;
    quiet_r > 4'h9 |-> $stable(WIPER_SETTING);
  endproperty
  a_quiet: assert property (p_quiet) else $error("wiper moved unprompted");
  property p_wp_hold;
    wp_r > 4'h7 |=> $stable(NV_OUTPUT_ONE) && $stable(NV_OUTPUT_TWO);
  endproperty
  a_wp_hold: assert property (p_wp_hold) else $error("store changed protected");
  c_slow: cover property ($fell(READY_OE_N) ##5 !READY_OE_N);
  c_preset: cover property ($rose(HW_PRESET_RELOAD));
  c_wp: cover property (wp_r > 4'h7 && !CS_N);
endmodule

bind digipot_control digipot_control_sva #(.WIPER_BITS(WIPER_BITS)) chk (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CS_N(CS_N),
  .WRITE_PROTECT_N(WRITE_PROTECT_N), .HW_PRESET_RELOAD(HW_PRESET_RELOAD),
  .SERIAL_OUT_O(SERIAL_OUT_O), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N),
  .READY_O(READY_O), .READY_OE_N(READY_OE_N), .NV_OUTPUT_ONE(NV_OUTPUT_ONE),
  .NV_OUTPUT_TWO(NV_OUTPUT_TWO), .WIPER_SETTING(WIPER_SETTING)
);

// *** tb/ucon_model.sv ***
// Purpose: controller model driving the serial command port
// Assumes: half period of 4 system cycles, clock idles low
// Notes: data line flips when deselected so no stale value lingers
module ucon_model (
  input wire logic clk,
  input wire logic serial_out_pin,
  output logic spi_clk,
  output logic serial_in,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_clk = 1'b0;
    serial_in = 1'b0;
    cs_n = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge clk);
    #5;
  endtask
  task automatic xfer(input logic [23:0] word, input int nbits, output logic [23:0] rx);
    rx = '0;
    cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in = word[i];
      half();
      rx = {rx[22:0], serial_out_pin};
      spi_clk = 1'b1;
      half();
      spi_clk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    serial_in = ~serial_in;
    half();
  endtask
endmodule

// *** tb/tb.sv ***
// Purpose: self-checking bench of the potentiometer control block
// Assumes: program time parameter 1, so slow commands stay busy 21 cycles
// Notes: an integer model tracks store, wiper and pending readback
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); fails++; end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wp_n = 1'b1;
  logic preset = 1'b0;
  logic spi_clk, ser_in, cs_n, ser_out_o, ser_out_oe_n, rdy_o, rdy_oe_n, nv1, nv2;
  logic [9:0] wiper;
  logic [23:0] rx;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int store[16];
  int wip;
  int rb;
  wire ser_out_pin = ser_out_oe_n ? 1'b1 : ser_out_o;
  wire rdy_pin = rdy_oe_n ? 1'b1 : rdy_o;
  always #25 sys_clk = ~sys_clk;
  ucon_model model (.clk(sys_clk), .serial_out_pin(ser_out_pin), .spi_clk(spi_clk),
    .serial_in(ser_in), .cs_n(cs_n));
  digipot_control #(.NV_PROG_TIME_US(1)) uut (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .SPI_CLK(spi_clk), .SERIAL_IN(ser_in),
    .CS_N(cs_n), .WRITE_PROTECT_N(wp_n), .HW_PRESET_RELOAD(preset),
    .SERIAL_OUT_O(ser_out_o), .SERIAL_OUT_OE_N(ser_out_oe_n), .READY_O(rdy_o),
    .READY_OE_N(rdy_oe_n), .NV_OUTPUT_ONE(nv1), .NV_OUTPUT_TWO(nv2),
    .WIPER_SETTING(wiper)
  );
  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask
  task automatic init_model();
    store = '{default: 0};
    store[0] = 512;
    wip = 512;
    rb = -1;
  endtask
  task automatic outs(input string nm);
    `CHK(nm, wip, wiper)
    `CHK("nv one", store[1] % 2, nv1)
    `CHK("nv two", store[1] / 2 % 2, nv2)
  endtask
  task automatic op(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    logic slow;
    int w;
    model.xfer({c, a, d}, 24, rx);
    if (rb >= 0) `CHK("readback", rb, rx[23:8])
    rb = -1;
    case (c)
      4'h1, 4'h8: wip = store[0] % 1024;
      4'h2: if (wp_n) store[0] = wip;
      4'h3: if (wp_n) store[a] = d;
      4'h9: rb = store[a];
      4'hA: rb = wip;
      4'hB: if (wp_n) wip = d % 1024;
      default: ;
    endcase
    // protected writes never go busy, so ready must stay released
    slow = (c inside {4'h8, 4'h9, 4'hA}) || (wp_n && c inside {4'h2, 4'h3});
    w = 0;
    while (rdy_pin === 1'b1 && w < 12) begin
      tick(1);
      w++;
    end
    `CHK("ready busy", slow, rdy_pin === 1'b0)
    while (rdy_pin !== 1'b1 && w < 60) begin
      tick(1);
      w++;
    end
    `CHK("ready free", 1'b1, rdy_pin)
    tick(2);
    outs("wiper");
  endtask
  task automatic preset_edge();
    preset = 1'b1;
    wip = store[0] % 1024;
    tick(10);
    outs("preset rise");
    op(4'hB, 4'h0, 16'($urandom));
    preset = 1'b0;
    tick(10);
    outs("preset fall");
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    int r;
    r = $urandom(32'hD035D908);
    init_model();
    tick(2);
    sys_rst = 1'b0;
    outs("reset");
    op(4'hB, 4'h0, 16'($urandom));
    preset_edge();
    op(4'h2, 4'h0, 16'h0000);
    op(4'hB, 4'h0, 16'($urandom));
    preset_edge();
    for (int i = 0; i < 4; i++) begin
      op(4'h3, 4'h1, {14'($urandom), 2'(i)});
    end
    op(4'h9, 4'h1, 16'h0000);
    op(4'hA, 4'h0, 16'h0000);
    op(4'hB, 4'h0, 16'($urandom));
    op(4'h8, 4'h0, 16'h0000);
    wp_n = 1'b0;
    tick(10);
    op(4'h3, 4'h1, 16'($urandom));
    op(4'hB, 4'h0, 16'($urandom));
    op(4'h2, 4'h0, 16'h0000);
    op(4'h1, 4'h0, 16'h0000);
    preset_edge();
    op(4'h9, 4'h1, 16'h0000);
    op(4'h0, 4'h0, 16'h0000);
    wp_n = 1'b1;
    r = $urandom;
    model.xfer({4'hB, 4'h0, 16'(r)}, 23, rx);
    tick(12);
    outs("short frame");
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    init_model();
    outs("second reset");
    complete_run();
  end
endmodule
